// >>> design/tuner_synth_config_regs.sv
// two-wire write port and configuration register bank of the tuner synthesizer
`timescale 1ns/1ps
// Function
// - pump minimum pulse field, bits 7-6, resets to 00; controller writes 00.
// - pump linearity field, bits 5-4, resets to 00; controller loads 01.
// - 20-bit fractional word spans three registers, reset 0x2F684.
// - crystal divider code, bits 7-5, resets 000; decoded to divide ratio.
// - reference divider bits 4-0 reset to 00001 meaning divide by one.
// - REG_SYNTH_PUMP_CONTROL post-divider bit 7 resets 1; 1 divides four, 0 two.
// - pump source select resets 1 (auto); else pump current bit picks current.
// - OSCILLATOR_SELECT select bits 7-3 reset to 11001, manual choice or start band.
// - autoselect enable bit 2 resets 1; 0 means bus-written OSCILLATOR_SELECT choice.
// - ADC latch bit acts only with autoselect off; resets 0.
// - ADC read enable acts only with autoselect off; resets 0.
// - filter register resets 01001011; controller rewrites it to 10010111.
// - standby bit shuts signal path and synthesizer; crystal and bus stay on.
// - baseband gain bits 3-0 reset 0000, about 1dB per step.
// - slave address 1100000 with address pin low, 1100001 with it high.
module tuner_synth_config_regs
  import tuner_cfg_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic addr_sel_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic [1:0] pump_min_pulse_o,
  output logic [1:0] pump_linearity_o,
  output logic [19:0] frac_divide_o,
  output logic [2:0] crystal_buffer_divider_o,
  output logic [3:0] crystal_div_ratio_o,
  output logic [4:0] ref_divider_o,
  output logic vco_post_divider_o,
  output logic pump_current_source_select_o,
  output logic pump_current_high_o,
  output logic [4:0] vco_select_o,
  output logic vco_autoselect_enable_o,
  output logic tune_adc_latch_o,
  output logic tune_adc_read_enable_o,
  output logic [7:0] filter_setting_o,
  output logic standby_request_o,
  output logic signal_path_enable_o,
  output logic synth_enable_o,
  output logic factory_power_off_o,
  output logic [3:0] baseband_gain_o
);
  typedef struct packed {
    link_state_t st;
    logic [BIT_CNT_W-1:0] bit_cnt;
    logic [BYTE_W-1:0] shreg;
    logic [BYTE_W-1:0] ptr;
    logic ack_drive;
    logic scl_q;
    logic sda_q;
    logic [NUM_REGS-1:0][BYTE_W-1:0] regs;
  } bank_state_t;

  bank_state_t s_r;
  bank_state_t s_nxt;
  logic [2:0] pins_sync;
  logic scl_s;
  logic sda_s;
  logic addr_s;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic byte_done;
  logic [6:0] own_addr;
  logic ptr_in_bank;
  logic [IDX_W-1:0] ptr_idx;
  logic data_write;

  pin_sync #(
    .WIDTH(3)
  ) u_pin_sync (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i({scl_i, sda_i, addr_sel_i}),
    .sync_o(pins_sync)
  );

  assign scl_s = pins_sync[2];
  assign sda_s = pins_sync[1];
  assign addr_s = pins_sync[0];

  // bus conditions come from synchronised copies, so a glitch narrower than a cycle is a hazard
  assign scl_rise = scl_s & ~s_r.scl_q;
  assign scl_fall = ~scl_s & s_r.scl_q;
  assign start_cond = scl_s & s_r.scl_q & s_r.sda_q & ~sda_s;
  assign stop_cond = scl_s & s_r.scl_q & ~s_r.sda_q & sda_s;
  assign byte_done = scl_fall & (s_r.bit_cnt == BITS_PER_BYTE);
  assign own_addr = addr_s ? SLAVE_ADDR_HIGH : SLAVE_ADDR_LOW;
  assign ptr_in_bank = (s_r.ptr >= REG_PUMP_AND_FRAC_HIGH) && (s_r.ptr <= REG_STANDBY_AND_GAIN);
  assign ptr_idx = IDX_W'(s_r.ptr - REG_PUMP_AND_FRAC_HIGH);
  assign data_write = (s_r.st == S_DATA) && byte_done && ptr_in_bank;

  function automatic logic [BYTE_W-1:0] store_mask(input logic [IDX_W-1:0] idx);
    logic [BYTE_W-1:0] m;
    m = MASK_FULL;
    if (idx == IDX_SYNTH) begin
      m = MASK_SYNTH_PUMP_CONTROL;
    end else if (idx == IDX_CTRL) begin
      m = MASK_STANDBY_AND_GAIN;
    end
    return m;
  endfunction

  always_comb begin
    s_nxt = s_r;
    s_nxt.scl_q = scl_s;
    s_nxt.sda_q = sda_s;
    if (start_cond) begin
      // a repeated start restarts address reception
      s_nxt.st = S_ADDR;
      s_nxt.bit_cnt = '0;
      s_nxt.ack_drive = 1'b0;
    end else if (stop_cond) begin
      s_nxt.st = S_IDLE;
      s_nxt.ack_drive = 1'b0;
    end else begin
      case (s_r.st)
        S_ADDR, S_REG, S_DATA: begin
          if (scl_rise) begin
            s_nxt.shreg = {s_r.shreg[BYTE_W-2:0], sda_s};
            s_nxt.bit_cnt = s_r.bit_cnt + 1'b1;
          end else if (byte_done) begin
            s_nxt.ack_drive = 1'b1;
            if (s_r.st == S_ADDR) begin
              if (s_r.shreg[7:1] == own_addr && s_r.shreg[0] == WRITE_DIR) begin
                s_nxt.st = S_ACK_ADDR;
              end else begin
                // reads of the status bytes are not served here
                s_nxt.st = S_IGNORE;
                s_nxt.ack_drive = 1'b0;
              end
            end else if (s_r.st == S_REG) begin
              s_nxt.ptr = s_r.shreg;
              s_nxt.st = S_ACK_REG;
            end else begin
              // bytes outside this bank are acknowledged and dropped
              if (ptr_in_bank) begin
                s_nxt.regs[ptr_idx] = s_r.shreg & store_mask(ptr_idx);
              end
              s_nxt.ptr = s_r.ptr + 1'b1;
              s_nxt.st = S_ACK_DATA;
            end
          end
        end
        S_ACK_ADDR, S_ACK_REG, S_ACK_DATA: begin
          if (scl_fall) begin
            s_nxt.ack_drive = 1'b0;
            s_nxt.bit_cnt = '0;
            s_nxt.st = (s_r.st == S_ACK_ADDR) ? S_REG : S_DATA;
          end
        end
        S_IDLE, S_IGNORE: begin
          s_nxt.ack_drive = 1'b0;
        end
        default: begin
          s_nxt.st = S_IDLE;
          s_nxt.ack_drive = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_r.st <= S_IDLE;
      s_r.bit_cnt <= '0;
      s_r.shreg <= '0;
      s_r.ptr <= '0;
      s_r.ack_drive <= 1'b0;
      s_r.scl_q <= 1'b1;
      s_r.sda_q <= 1'b1;
      s_r.regs[IDX_PUMP] <= RST_PUMP_AND_FRAC_HIGH;
      s_r.regs[IDX_FRAC_MID] <= RST_FRAC_DIVIDE_MID;
      s_r.regs[IDX_FRAC_LOW] <= RST_FRAC_DIVIDE_LOW;
      s_r.regs[IDX_XTAL_REF] <= RST_CRYSTAL_AND_REF_DIVIDER;
      s_r.regs[IDX_SYNTH] <= RST_SYNTH_PUMP_CONTROL;
      s_r.regs[IDX_OSC] <= RST_OSCILLATOR_SELECT;
      s_r.regs[IDX_FILTER] <= RST_FILTER_SETTING;
      s_r.regs[IDX_CTRL] <= RST_STANDBY_AND_GAIN;
    end else begin
      s_r <= s_nxt;
    end
  end

  // open-drain: only ever pull low
  assign sda_o = 1'b0;
  assign sda_oe_o = s_r.ack_drive;

  assign pump_min_pulse_o = s_r.regs[IDX_PUMP][PUMP_MIN_PULSE_LSB +: 2];
  assign pump_linearity_o = s_r.regs[IDX_PUMP][PUMP_LINEARITY_LSB +: 2];
  assign frac_divide_o = {s_r.regs[IDX_PUMP][FRAC_HIGH_LSB +: FRAC_HIGH_W], s_r.regs[IDX_FRAC_MID],
                          s_r.regs[IDX_FRAC_LOW]};
  assign crystal_buffer_divider_o = s_r.regs[IDX_XTAL_REF][XTAL_DIV_LSB +: 3];
  assign ref_divider_o = s_r.regs[IDX_XTAL_REF][REF_DIV_LSB +: 5];
  assign vco_post_divider_o = s_r.regs[IDX_SYNTH][VCO_POST_DIV_BIT];
  assign pump_current_source_select_o = s_r.regs[IDX_SYNTH][PUMP_SRC_SEL_BIT];
  // the current bit is ignored by the pump while the autoselect circuit owns it
  assign pump_current_high_o = s_r.regs[IDX_SYNTH][PUMP_CUR_HIGH_BIT] & ~pump_current_source_select_o;
  assign vco_select_o = s_r.regs[IDX_OSC][VCO_SEL_LSB +: 5];
  assign vco_autoselect_enable_o = s_r.regs[IDX_OSC][VCO_AUTO_BIT];
  assign tune_adc_latch_o = s_r.regs[IDX_OSC][ADC_LATCH_BIT] & ~vco_autoselect_enable_o;
  assign tune_adc_read_enable_o = s_r.regs[IDX_OSC][ADC_READ_BIT] & ~vco_autoselect_enable_o;
  assign filter_setting_o = s_r.regs[IDX_FILTER];
  assign standby_request_o = s_r.regs[IDX_CTRL][STANDBY_BIT];
  // crystal buffer and its divider have no gate: they run through standby
  assign signal_path_enable_o = ~standby_request_o;
  assign synth_enable_o = ~standby_request_o;
  assign factory_power_off_o = s_r.regs[IDX_CTRL][FACTORY_OFF_BIT];
  assign baseband_gain_o = s_r.regs[IDX_CTRL][BB_GAIN_LSB +: 4];

  // code 010 has no defined ratio and reports zero
  always_comb begin
    case (crystal_buffer_divider_o)
      XD_DIV1: crystal_div_ratio_o = RATIO_1;
      XD_DIV2: crystal_div_ratio_o = RATIO_2;
      XD_DIV3: crystal_div_ratio_o = RATIO_3;
      XD_DIV4: crystal_div_ratio_o = RATIO_4;
      XD_DIV5: crystal_div_ratio_o = RATIO_5;
      XD_DIV7: crystal_div_ratio_o = RATIO_7;
      XD_DIV8: crystal_div_ratio_o = RATIO_8;
      XD_UNDEF: crystal_div_ratio_o = RATIO_UNDEF;
      default: crystal_div_ratio_o = RATIO_UNDEF;
    endcase
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  a_addr_ack_match: assert property (
    (s_r.st == S_ADDR && byte_done && s_r.shreg[7:1] == own_addr && s_r.shreg[0] == WRITE_DIR && !start_cond
     && !stop_cond) |=> sda_oe_o ##0 s_r.st == S_ACK_ADDR)
    else $error("own write address not acknowledged");
  a_foreign_silent: assert property (
    (s_r.st == S_ADDR && byte_done && s_r.shreg[7:1] != own_addr && !start_cond && !stop_cond)
    |=> !sda_oe_o throughout (s_r.st == S_IGNORE) [*2])
    else $error("foreign address drove the data line");
  a_write_lands: assert property (
    (data_write && ptr_idx == IDX_FILTER && !start_cond && !stop_cond)
    |=> filter_setting_o == $past(s_r.shreg))
    else $error("filter byte not stored");
  a_regs_hold: assert property (
    !data_write |=> $stable(s_r.regs))
    else $error("register changed without a data byte");
  a_dont_care_zero: assert property (
    s_r.regs[IDX_SYNTH][PUMP_CUR_HIGH_BIT-1:0] == '0 && s_r.regs[IDX_CTRL][STANDBY_BIT-1] == 1'b0
    && s_r.regs[IDX_CTRL][FACTORY_OFF_BIT-1] == 1'b0)
    else $error("don't-care bit stored");
  a_frac_order: assert property (
    (data_write && ptr_idx == IDX_FRAC_LOW && !start_cond && !stop_cond)
    |=> frac_divide_o[BYTE_W-1:0] == $past(s_r.shreg) && $stable(frac_divide_o[19:BYTE_W]))
    else $error("fractional low byte misplaced");
  a_standby_gates: assert property (
    standby_request_o |-> !signal_path_enable_o && !synth_enable_o)
    else $error("standby left signal path on");
  a_adc_latch_gate: assert property (
    vco_autoselect_enable_o |-> !tune_adc_latch_o)
    else $error("adc latch active under autoselect");
  a_adc_read_gate: assert property (
    (!vco_autoselect_enable_o && s_r.regs[IDX_OSC][ADC_READ_BIT]) |-> tune_adc_read_enable_o)
    else $error("adc read blocked in manual mode");
  a_xtal_ratio: assert property (
    (crystal_buffer_divider_o == XD_DIV8 |-> crystal_div_ratio_o == RATIO_8)
    and (crystal_buffer_divider_o == XD_DIV3 |-> crystal_div_ratio_o == RATIO_3))
    else $error("crystal divide ratio wrong");
  a_ack_release: assert property (
    (s_r.st == S_ACK_DATA && scl_fall && !start_cond && !stop_cond) |=> !sda_oe_o && s_r.st == S_DATA)
    else $error("acknowledge not released after ninth clock");
  a_pump_cur_gate: assert property (
    pump_current_source_select_o |-> !pump_current_high_o)
    else $error("pump current bit active under autoselect");
  a_pump_cur_manual: assert property (
    (!pump_current_source_select_o && s_r.regs[IDX_SYNTH][PUMP_CUR_HIGH_BIT]) |-> pump_current_high_o)
    else $error("pump current bit ignored in manual mode");
  a_adc_read_auto: assert property (
    vco_autoselect_enable_o |-> !tune_adc_read_enable_o)
    else $error("adc read active under autoselect");
  a_adc_latch_manual: assert property (
    (!vco_autoselect_enable_o && s_r.regs[IDX_OSC][ADC_LATCH_BIT]) |-> tune_adc_latch_o)
    else $error("adc latch blocked in manual mode");
  a_standby_off_runs: assert property (
    !standby_request_o |-> signal_path_enable_o && synth_enable_o)
    else $error("signal path off outside standby");
  a_reg_byte_ack: assert property (
    (s_r.st == S_REG && byte_done && !start_cond && !stop_cond)
    |=> sda_oe_o && s_r.st == S_ACK_REG && s_r.ptr == $past(s_r.shreg))
    else $error("register address byte not taken");
  a_data_ack_ptr: assert property (
    (s_r.st == S_DATA && byte_done && !start_cond && !stop_cond)
    |=> sda_oe_o && s_r.ptr == $past(s_r.ptr) + 8'h01)
    else $error("data byte not acknowledged or pointer stuck");
  a_start_restart: assert property (
    start_cond |=> s_r.st == S_ADDR && s_r.bit_cnt == '0 && !sda_oe_o)
    else $error("start did not restart address reception");
  a_stop_idle: assert property (
    stop_cond |=> s_r.st == S_IDLE && !sda_oe_o)
    else $error("stop did not return the port to idle");
endmodule

// >>> design/tuner_cfg_pkg.sv
// constants for the tuner synthesizer configuration register bank
package tuner_cfg_pkg;
  localparam int BYTE_W = 8;
  localparam int NUM_REGS = 8;
  localparam int IDX_W = 3;
  localparam int BIT_CNT_W = 4;
  localparam logic [BIT_CNT_W-1:0] BITS_PER_BYTE = 4'h8;
  // two-wire slave address, selected by the address pin
  localparam logic [6:0] SLAVE_ADDR_LOW = 7'h60;
  localparam logic [6:0] SLAVE_ADDR_HIGH = 7'h61;
  localparam logic WRITE_DIR = 1'h0;
  // register offsets
  localparam logic [7:0] REG_PUMP_AND_FRAC_HIGH = 8'h02;
  localparam logic [7:0] REG_FRAC_DIVIDE_MID = 8'h03;
  localparam logic [7:0] REG_FRAC_DIVIDE_LOW = 8'h04;
  localparam logic [7:0] REG_CRYSTAL_AND_REF_DIVIDER = 8'h05;
  localparam logic [7:0] REG_SYNTH_PUMP_CONTROL = 8'h06;
  localparam logic [7:0] REG_OSCILLATOR_SELECT = 8'h07;
  localparam logic [7:0] REG_FILTER_SETTING = 8'h08;
  localparam logic [7:0] REG_STANDBY_AND_GAIN = 8'h09;
  // array indices
  localparam logic [IDX_W-1:0] IDX_PUMP = 3'h0;
  localparam logic [IDX_W-1:0] IDX_FRAC_MID = 3'h1;
  localparam logic [IDX_W-1:0] IDX_FRAC_LOW = 3'h2;
  localparam logic [IDX_W-1:0] IDX_XTAL_REF = 3'h3;
  localparam logic [IDX_W-1:0] IDX_SYNTH = 3'h4;
  localparam logic [IDX_W-1:0] IDX_OSC = 3'h5;
  localparam logic [IDX_W-1:0] IDX_FILTER = 3'h6;
  localparam logic [IDX_W-1:0] IDX_CTRL = 3'h7;
  // reset values
  localparam logic [7:0] RST_PUMP_AND_FRAC_HIGH = 8'h02;
  localparam logic [7:0] RST_FRAC_DIVIDE_MID = 8'hF6;
  localparam logic [7:0] RST_FRAC_DIVIDE_LOW = 8'h84;
  localparam logic [7:0] RST_CRYSTAL_AND_REF_DIVIDER = 8'h01;
  localparam logic [7:0] RST_SYNTH_PUMP_CONTROL = 8'hC0;
  localparam logic [7:0] RST_OSCILLATOR_SELECT = 8'hCC;
  localparam logic [7:0] RST_FILTER_SETTING = 8'h4B;
  localparam logic [7:0] RST_STANDBY_AND_GAIN = 8'h00;
  // storable bits; don't-care bits are kept at zero
  localparam logic [7:0] MASK_SYNTH_PUMP_CONTROL = 8'hE0;
  localparam logic [7:0] MASK_STANDBY_AND_GAIN = 8'hAF;
  localparam logic [7:0] MASK_FULL = 8'hFF;
  // field positions
  localparam int PUMP_MIN_PULSE_LSB = 6;
  localparam int PUMP_LINEARITY_LSB = 4;
  localparam int FRAC_HIGH_LSB = 0;
  localparam int FRAC_HIGH_W = 4;
  localparam int XTAL_DIV_LSB = 5;
  localparam int REF_DIV_LSB = 0;
  localparam int VCO_POST_DIV_BIT = 7;
  localparam int PUMP_SRC_SEL_BIT = 6;
  localparam int PUMP_CUR_HIGH_BIT = 5;
  localparam int VCO_SEL_LSB = 3;
  localparam int VCO_AUTO_BIT = 2;
  localparam int ADC_LATCH_BIT = 1;
  localparam int ADC_READ_BIT = 0;
  localparam int STANDBY_BIT = 7;
  localparam int FACTORY_OFF_BIT = 5;
  localparam int BB_GAIN_LSB = 0;
  // crystal buffer divider codes and ratios
  localparam logic [2:0] XD_DIV1 = 3'h0;
  localparam logic [2:0] XD_DIV2 = 3'h1;
  localparam logic [2:0] XD_UNDEF = 3'h2;
  localparam logic [2:0] XD_DIV3 = 3'h3;
  localparam logic [2:0] XD_DIV4 = 3'h4;
  localparam logic [2:0] XD_DIV5 = 3'h5;
  localparam logic [2:0] XD_DIV7 = 3'h6;
  localparam logic [2:0] XD_DIV8 = 3'h7;
  localparam logic [3:0] RATIO_UNDEF = 4'h0;
  localparam logic [3:0] RATIO_1 = 4'h1;
  localparam logic [3:0] RATIO_2 = 4'h2;
  localparam logic [3:0] RATIO_3 = 4'h3;
  localparam logic [3:0] RATIO_4 = 4'h4;
  localparam logic [3:0] RATIO_5 = 4'h5;
  localparam logic [3:0] RATIO_7 = 4'h7;
  localparam logic [3:0] RATIO_8 = 4'h8;
  typedef enum {S_IDLE, S_ADDR, S_ACK_ADDR, S_REG, S_ACK_REG, S_DATA, S_ACK_DATA, S_IGNORE} link_state_t;
endpackage

// >>> design/pin_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_state_t;

  sync_state_t st_r;
  sync_state_t st_nxt;

  // the first stage feeds only the second stage
  always_comb begin
    st_nxt.first = async_i;
    st_nxt.second = st_r.first;
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      // bus pins idle high; resetting to that level keeps a false edge out of the first cycles
      st_r <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_o = st_r.second;
endmodule

// >>> bench/i2c_ctrl_model.sv
// two-wire bus controller model that writes the tuner register bank
`timescale 1ns/1ps
module i2c_ctrl_model (
  input wire logic core_clk_i,
  input wire logic sda_line_i,
  output logic scl_o,
  output logic sda_low_o,
  output logic done_o
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
    done_o = 1'b0;
  end
  task automatic wait_c(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task automatic start_c();
    wait_c(5);
    sda_low_o <= 1'b1;
    wait_c(5);
    scl_o <= 1'b0;
  endtask
  // five-clock halves keep both scl phases above the four-clock minimum
  task automatic bit_c(input logic b, output logic s);
    wait_c(2);
    sda_low_o <= ~b;
    wait_c(3);
    scl_o <= 1'b1;
    wait_c(3);
    s = sda_line_i;
    wait_c(2);
    scl_o <= 1'b0;
  endtask
  task automatic byte_c(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_c(b[i], s);
    // released line lets the pull-up show a refusal
    bit_c(1'b1, s);
    ack = ~s;
  endtask
  task automatic stop_c();
    wait_c(2);
    sda_low_o <= 1'b1;
    wait_c(3);
    scl_o <= 1'b1;
    wait_c(5);
    sda_low_o <= 1'b0;
    done_o <= 1'b1;
    wait_c(1);
    done_o <= 1'b0;
  endtask
endmodule

// >>> bench/tb_top.sv
// self-checking bench for the tuner synthesizer configuration register bank
`timescale 1ns/1ps
`define CHK(g, e, m) begin total_checks++; if ((g) !== (e)) begin bad_count++; $display("wrong value at %0t: %s", $time, m); end end
module tb_top;
  import tuner_cfg_pkg::*;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic addr_sel = 1'b0;
  logic chk_req = 1'b0;
  logic scl, m_low, done, sda_o_w, sda_oe, sda_w;
  logic [1:0] pmp, lin;
  logic [19:0] frac;
  logic [2:0] xd;
  logic [3:0] ratio, gain;
  logic [4:0] refd, vsel;
  logic post, src, cur, vauto, latch, rd, standby_request, spen, syen, factory_power_off;
  logic [7:0] filt;
  logic [7:0][7:0] bank;
  logic [7:0][7:0] notes[$];
  int bad_count = 0;
  int total_checks = 0;
  // open-drain line with pull-up
  assign sda_w = ~(m_low | (sda_oe & ~sda_o_w));
  initial begin
    forever #20 core_clk_i = ~core_clk_i;
  end
  i2c_ctrl_model i2c_ctrl_model_i (.core_clk_i(core_clk_i), .sda_line_i(sda_w), .scl_o(scl),
    .sda_low_o(m_low), .done_o(done));
  tuner_synth_config_regs tuner_synth_config_regs_i (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .scl_i(scl), .sda_i(sda_w), .addr_sel_i(addr_sel), .sda_o(sda_o_w), .sda_oe_o(sda_oe),
    .pump_min_pulse_o(pmp), .pump_linearity_o(lin), .frac_divide_o(frac), .crystal_buffer_divider_o(xd),
    .crystal_div_ratio_o(ratio), .ref_divider_o(refd), .vco_post_divider_o(post),
    .pump_current_source_select_o(src), .pump_current_high_o(cur), .vco_select_o(vsel),
    .vco_autoselect_enable_o(vauto), .tune_adc_latch_o(latch), .tune_adc_read_enable_o(rd),
    .filter_setting_o(filt), .standby_request_o(standby_request), .signal_path_enable_o(spen),
    .synth_enable_o(syen), .factory_power_off_o(factory_power_off), .baseband_gain_o(gain));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [3:0] xd_ratio(input logic [2:0] c);
    logic [3:0] t [8] = '{4'h1, 4'h2, 4'h0, 4'h3, 4'h4, 4'h5, 4'h7, 4'h8};
    return t[c];
  endfunction
  task automatic check_img(input logic [7:0][7:0] b);
    `CHK(pmp, b[0][7:6], "pump min pulse")
    `CHK(lin, b[0][5:4], "pump linearity")
    `CHK(frac, {b[0][3:0], b[1], b[2]}, "frac word")
    `CHK(xd, b[3][7:5], "crystal code")
    `CHK(ratio, xd_ratio(b[3][7:5]), "crystal ratio")
    `CHK(refd, b[3][4:0], "ref divider")
    `CHK(post, b[4][7], "post divider")
    `CHK(src, b[4][6], "pump source")
    `CHK(cur, b[4][5] & ~b[4][6], "pump current")
    `CHK(vsel, b[5][7:3], "vco select")
    `CHK(vauto, b[5][2], "autoselect")
    `CHK(latch, b[5][1] & ~b[5][2], "adc latch")
    `CHK(rd, b[5][0] & ~b[5][2], "adc read")
    `CHK(filt, b[6], "filter")
    `CHK({standby_request, spen, syen}, {b[7][7], ~b[7][7], ~b[7][7]}, "standby")
    `CHK(factory_power_off, b[7][5], "factory off")
    `CHK(gain, b[7][3:0], "gain")
  endtask
  always @(posedge core_clk_i) begin
    if (done || chk_req) begin
      if (notes.size() == 0) `CHK(1'b0, 1'b1, "result without note")
      else check_img(notes.pop_front());
    end
  end
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic do_reset();
    sys_rst_i <= 1'b1;
    repeat (5) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    bank = {8'h00, 8'h4B, 8'hCC, 8'hC0, 8'h01, 8'h84, 8'hF6, 8'h02};
    notes.push_back(bank);
    chk_req <= 1'b1;
    @(posedge core_clk_i);
    chk_req <= 1'b0;
  endtask
  // note is queued before stop so the watcher never sees the result first
  task automatic frame(input logic [7:0] dev, input logic [7:0] ptr, input logic [7:0] d[$], input logic exp_ack);
    logic ack;
    i2c_ctrl_model_i.start_c();
    i2c_ctrl_model_i.byte_c(dev, ack);
    `CHK(ack, exp_ack, "address ack")
    if (ack === 1'b1) begin
      i2c_ctrl_model_i.byte_c(ptr, ack);
      `CHK(ack, 1'b1, "pointer ack")
      foreach (d[i]) begin
        i2c_ctrl_model_i.byte_c(d[i], ack);
        `CHK(ack, 1'b1, "data ack")
        if (ptr >= 8'h02 && ptr <= 8'h09) bank[3'(ptr - 8'h02)] = d[i];
        ptr++;
      end
    end
    notes.push_back(bank);
    i2c_ctrl_model_i.stop_c();
  endtask
  initial begin
    logic [31:0] rnd;
    logic [7:0] p, v;
    rnd = 32'h50782400;
    do_reset();
    repeat (2500) @(posedge core_clk_i);
    // full power-up load, from 0x00 past 0x09, dropping bytes outside the bank
    frame(8'hC0, 8'h00, '{8'h55, 8'hAA, 8'h1F, 8'h12, 8'h34, 8'hE1, 8'h40, 8'h3B, 8'h97, 8'h8F, 8'hFF},
      1'b1);
    for (int c = 0; c < 8; c++) frame(8'hC0, 8'h05, '{{3'(c), 5'h01}}, 1'b1);
    frame(8'hC0, 8'h06, '{8'h3F, 8'h26}, 1'b1);
    frame(8'hC2, 8'h09, '{8'h00}, 1'b0);
    frame(8'hC1, 8'h09, '{8'h00}, 1'b0);
    addr_sel <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    frame(8'hC2, 8'h09, '{8'h05}, 1'b1);
    frame(8'hC0, 8'h09, '{8'h8F}, 1'b0);
    addr_sel <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    repeat (30) begin
      rnd = lfsr(rnd);
      p = 8'h02 + {5'h00, rnd[2:0]};
      v = rnd[15:8];
      if (p == 8'h09) v[5] = 1'b0;
      frame(8'hC0, p, '{v}, 1'b1);
    end
    do_reset();
    wrap_up();
  end
  initial begin
    repeat (60000) @(posedge core_clk_i);
    bad_count++;
    wrap_up();
  end
endmodule
